// file: rtl/ibm_channel.sv
// One bus-master channel: command, status and descriptor pointer
`timescale 1ns/100ps
module ibm_channel
  import ibm_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        cmd_wr_in,
  input  wire logic        stat_wr_in,
  input  wire logic        ptr_wr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        prd_done_in,
  input  wire logic        xfer_done_in,
  input  wire logic        irq_in,
  input  wire logic        err_in,
  output logic      [7:0]  cmd_q,
  output logic      [7:0]  stat_q,
  output logic      [31:0] ptr_q,
  output logic             running_q,
  output logic             abort_q
);
  ibm_state_type state_q;
  ibm_state_type state_d;
  logic [31:0]   ptr_d;
  logic [7:0]    cmd_d;
  logic [7:0]    stat_d;
  wire  start_w  = cmd_wr_in & wdata_in[IBM_CMD_START_BIT];
  wire  stop_w   = cmd_wr_in & ~wdata_in[IBM_CMD_START_BIT];
  wire  run_w    = (state_q == IBM_RUN);
  wire  end_w    = run_w & (stop_w | xfer_done_in | err_in);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      IBM_IDLE: if (start_w) state_d = IBM_RUN;
      IBM_RUN:  if (end_w) state_d = IBM_IDLE;
    endcase
  end

  always_comb begin
    cmd_d = cmd_q;
    if (cmd_wr_in) begin
      cmd_d = 8'h00;
      cmd_d[IBM_CMD_START_BIT] = wdata_in[IBM_CMD_START_BIT];
      cmd_d[IBM_CMD_DIR_BIT]   = wdata_in[IBM_CMD_DIR_BIT];
    end
  end

  always_comb begin
    stat_d = stat_q & 8'h67;
    stat_d[IBM_ST_SIMPLEX_BIT] = 1'b0;
    if (stat_wr_in) begin
      stat_d[IBM_ST_DRV1_BIT] = wdata_in[IBM_ST_DRV1_BIT];
      stat_d[IBM_ST_DRV0_BIT] = wdata_in[IBM_ST_DRV0_BIT];
      if (wdata_in[IBM_ST_INT_BIT])
        stat_d[IBM_ST_INT_BIT] = 1'b0;
      if (wdata_in[IBM_ST_ERR_BIT])
        stat_d[IBM_ST_ERR_BIT] = 1'b0;
    end
    // Set beats a same-cycle write-1 clear
    if (irq_in)
      stat_d[IBM_ST_INT_BIT] = 1'b1;
    if (err_in & run_w)
      stat_d[IBM_ST_ERR_BIT] = 1'b1;
    stat_d[IBM_ST_ACTIVE_BIT] = (state_d == IBM_RUN);
  end

  always_comb begin
    ptr_d = ptr_q;
    if (ptr_wr_in && !run_w)
      ptr_d = {wdata_in[31:2], 2'b00};
    else if (run_w && prd_done_in && !end_w)
      ptr_d = ptr_q + IBM_PRD_STEP;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_q   <= IBM_IDLE;
      cmd_q     <= IBM_CMD_RESET;
      stat_q    <= IBM_STAT_RESET;
      ptr_q     <= IBM_PTR_RESET;
      running_q <= 1'b0;
      abort_q   <= 1'b0;
    end else begin
      state_q   <= state_d;
      cmd_q     <= cmd_d;
      stat_q    <= stat_d;
      ptr_q     <= ptr_d;
      running_q <= (state_d == IBM_RUN);
      abort_q   <= run_w & stop_w;
    end
  end
endmodule

// file: rtl/ibm_pkg.sv
// Constants and types for the IDE bus-master DMA control block
// Operation
// - Command bit 3 picks direction: 0 memory reads, 1 memory writes.
// - Command bit 0 written 1 enables the master, written 0 disables.
// - Clearing start/stop halts any ongoing bus-master operation.
// - Clearing start/stop mid-transfer aborts and discards drive data.
// - Reserved command 7:4, 2:1 and status 4:3 read zero.
// - Status bit 7 is read-only simplex flag, 1 means simplex.
// - Status bits 6 and 5 are writable drive 1/drive 0 DMA-capable flags.
// - Status bit 2 sets on interrupt, clears on write of 1.
// - Status bit 1 sets on transfer error, clears on write of 1.
// - Status bit 0 is read-only, 1 while the master is active.
// - Pointer write bits 31:2 give table start; bits 1:0 are zero.
// - Once enabled, pointer ignores writes and advances by 08h per descriptor.
// - Pointer reads return the next descriptor address.
// - Secondary channel has identical registers, command at 08h.
package ibm_pkg;
  localparam logic [7:0] IBM_OFF_PRI_CMD  = 8'h00;
  localparam logic [7:0] IBM_OFF_PRI_STAT = 8'h02;
  localparam logic [7:0] IBM_OFF_PRI_PTR  = 8'h04;
  localparam logic [7:0] IBM_OFF_SEC_CMD  = 8'h08;
  localparam logic [7:0] IBM_OFF_SEC_STAT = 8'h0a;
  localparam logic [7:0] IBM_OFF_SEC_PTR  = 8'h0c;
  localparam logic [7:0] IBM_CHAN_STRIDE  = 8'h08;
  localparam int IBM_CMD_START_BIT = 0;
  localparam int IBM_CMD_DIR_BIT   = 3;
  localparam int IBM_ST_ACTIVE_BIT = 0;
  localparam int IBM_ST_ERR_BIT    = 1;
  localparam int IBM_ST_INT_BIT    = 2;
  localparam int IBM_ST_DRV0_BIT   = 5;
  localparam int IBM_ST_DRV1_BIT   = 6;
  localparam int IBM_ST_SIMPLEX_BIT = 7;
  localparam logic [7:0]  IBM_CMD_RESET  = 8'h00;
  localparam logic [7:0]  IBM_STAT_RESET = 8'h00;
  localparam logic [31:0] IBM_PTR_RESET  = 32'h0000_0000;
  localparam logic [31:0] IBM_PRD_STEP   = 32'h0000_0008;
  typedef enum logic [1:0] {
    IBM_IDLE,
    IBM_RUN
  } ibm_state_type;
endpackage

// file: rtl/ibm_top.sv
// Two-channel IDE bus-master DMA control register block
`timescale 1ns/100ps
module ibm_top
  import ibm_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic [1:0]  prd_done_in,
  input  wire logic [1:0]  xfer_done_in,
  input  wire logic [1:0]  drive_irq_in,
  input  wire logic [1:0]  xfer_err_in,
  output logic      [31:0] reg_rdata_out,
  output logic      [1:0]  run_out,
  output logic      [1:0]  mem_write_out,
  output logic      [1:0]  abort_out,
  output logic      [63:0] prd_addr_out
);
  import ibm_pkg::*;
  logic [7:0]  cmd_w   [2];
  logic [7:0]  stat_w  [2];
  logic [31:0] ptr_w   [2];
  logic [1:0]  run_w;
  logic [1:0]  abort_w;
  logic [31:0] rdata_d;
  logic [1:0]  irq_s1;
  logic [1:0]  irq_s2;
  logic [1:0]  done_s1;
  logic [1:0]  done_s2;
  logic [1:0]  err_s1;
  logic [1:0]  err_s2;
  logic [1:0]  xd_s1;
  logic [1:0]  xd_s2;

  // Drive-side events come from outside the clock domain
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      irq_s1  <= 2'b00;
      irq_s2  <= 2'b00;
      done_s1 <= 2'b00;
      done_s2 <= 2'b00;
      err_s1  <= 2'b00;
      err_s2  <= 2'b00;
      xd_s1   <= 2'b00;
      xd_s2   <= 2'b00;
    end else begin
      irq_s1  <= drive_irq_in;
      irq_s2  <= irq_s1;
      done_s1 <= prd_done_in;
      done_s2 <= done_s1;
      err_s1  <= xfer_err_in;
      err_s2  <= err_s1;
      xd_s1   <= xfer_done_in;
      xd_s2   <= xd_s1;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      // Channel base offsets are one stride apart
      localparam logic [7:0] BASE = 8'(ch) * IBM_CHAN_STRIDE;
      wire hit_cmd  = reg_wr_in && reg_addr_in == BASE + IBM_OFF_PRI_CMD;
      wire hit_stat = reg_wr_in && reg_addr_in == BASE + IBM_OFF_PRI_STAT;
      wire hit_ptr  = reg_wr_in && reg_addr_in == BASE + IBM_OFF_PRI_PTR;
      ibm_channel u_chan (
        .sys_clk_in   (sys_clk_in),
        .rst_in       (rst_in),
        .cmd_wr_in    (hit_cmd),
        .stat_wr_in   (hit_stat),
        .ptr_wr_in    (hit_ptr),
        .wdata_in     (reg_wdata_in),
        .prd_done_in  (done_s2[ch]),
        .xfer_done_in (xd_s2[ch]),
        .irq_in       (irq_s2[ch]),
        .err_in       (err_s2[ch]),
        .cmd_q        (cmd_w[ch]),
        .stat_q       (stat_w[ch]),
        .ptr_q        (ptr_w[ch]),
        .running_q    (run_w[ch]),
        .abort_q      (abort_w[ch])
      );
    end
  endgenerate

  // Each register read alone; byte offset picks one register
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (reg_addr_in)
      IBM_OFF_PRI_CMD:  rdata_d = {24'h00_0000, cmd_w[0]};
      IBM_OFF_PRI_STAT: rdata_d = {24'h00_0000, stat_w[0]};
      IBM_OFF_PRI_PTR:  rdata_d = ptr_w[0];
      IBM_OFF_SEC_CMD:  rdata_d = {24'h00_0000, cmd_w[1]};
      IBM_OFF_SEC_STAT: rdata_d = {24'h00_0000, stat_w[1]};
      IBM_OFF_SEC_PTR:  rdata_d = ptr_w[1];
      default:          rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
      run_out       <= 2'b00;
      mem_write_out <= 2'b00;
      abort_out     <= 2'b00;
      prd_addr_out  <= 64'h0000_0000_0000_0000;
    end else begin
      if (reg_rd_in)
        reg_rdata_out <= rdata_d;
      run_out       <= run_w;
      mem_write_out <= {cmd_w[1][IBM_CMD_DIR_BIT],
                        cmd_w[0][IBM_CMD_DIR_BIT]};
      abort_out     <= abort_w;
      prd_addr_out  <= {ptr_w[1], ptr_w[0]};
    end
  end
endmodule

// file: testbench/ibm_checker.sv
// Port assertions for the bus-master control block
`timescale 1ns/100ps
module ibm_checker (
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic [1:0]  run_out,
  input wire logic [1:0]  mem_write_out,
  input wire logic [1:0]  abort_out,
  input wire logic [63:0] prd_addr_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  wire logic wr0 = reg_wr_in && reg_addr_in == 8'h00;
  property dir_p;
    logic d;
    (wr0, d = reg_wdata_in[3]) |-> ##2 mem_write_out[0] == d;
  endproperty
  chk_start_runs:
    assert property (wr0 && reg_wdata_in[0] && !run_out[0]
      |-> ##[2:3] run_out[0]) else $error("run not raised");
  chk_stop_aborts:
    assert property (wr0 && !reg_wdata_in[0] && run_out[0]
      |-> ##[2:3] abort_out[0]) else $error("no abort");
  chk_abort_pulse:
    assert property (abort_out[0] |=> !abort_out[0]) else $error("long abort");
  chk_abort_idle:
    assert property ($rose(abort_out[0]) |-> !run_out[0]) else $error("busy");
  chk_dir_bit:
    assert property (dir_p) else $error("direction wrong");
  chk_ptr_step:
    assert property (run_out[0] && $past(run_out[0])
      && $changed(prd_addr_out[31:0]) |-> prd_addr_out[31:0]
      == $past(prd_addr_out[31:0]) + 32'h0000_0008) else $error("bad step");
  chk_ptr_align:
    assert property (prd_addr_out[1:0] == 2'b00
      && prd_addr_out[33:32] == 2'b00) else $error("pointer low bits");
  chk_cmd_rsvd:
    assert property ($past(reg_rd_in) && $past(reg_addr_in) == 8'h00
      |-> reg_rdata_out[7:4] == 4'h0 && reg_rdata_out[2:1] == 2'b00)
      else $error("command reserved");
  chk_stat_fixed:
    assert property ($past(reg_rd_in) && $past(reg_addr_in) == 8'h02
      |-> reg_rdata_out[7] == 1'b0 && reg_rdata_out[4:3] == 2'b00)
      else $error("status fixed bits");
  cover property (abort_out[0]);
  cover property (run_out[1] ##1 !run_out[1]);
  cover property (run_out[0] && $changed(prd_addr_out[31:0]));
endmodule
bind ibm_top ibm_checker u_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .run_out(run_out), .mem_write_out(mem_write_out),
  .abort_out(abort_out), .prd_addr_out(prd_addr_out));

// file: testbench/ibm_drive_model.sv
// Drive and memory stand-in pacing descriptor and end events
`timescale 1ns/100ps
module ibm_drive_model (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic [1:0] run_in,
  input  wire logic [1:0] go_in,
  input  wire logic [1:0] fail_in,
  output logic      [1:0] prd_done_out,
  output logic      [1:0] xfer_done_out,
  output logic      [1:0] irq_out,
  output logic      [1:0] err_out
);
  logic [3:0] cnt_q [2];
  for (genvar i = 0; i < 2; i++) begin : g_ch
    // A halted master silences the drive, so no late events
    // Rising edge, so the bench's falling-edge requests never race
    always @(posedge sys_clk_in) begin
      if (rst_in || !run_in[i])
        cnt_q[i] <= 4'h0;
      else if (go_in[i])
        cnt_q[i] <= 4'h1;
      else if (cnt_q[i] != 4'h0)
        cnt_q[i] <= cnt_q[i] + 4'h1;
    end
    assign prd_done_out[i] = cnt_q[i] == 4'h4 ||
                             (!fail_in[i] && cnt_q[i] == 4'h8);
    assign xfer_done_out[i] = !fail_in[i] && cnt_q[i] == 4'hc;
    assign irq_out[i] = xfer_done_out[i];
    assign err_out[i] = fail_in[i] && cnt_q[i] == 4'hc;
  end
endmodule

// file: testbench/ibm_tb_top.sv
// Register-level test of the two-channel bus-master control block
`timescale 1ns/100ps
module ibm_tb_top;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [1:0] go = 2'b00, fail = 2'b10, pdone, xdone, irq, err, run, mw, ab;
  logic [63:0] paddr;
  int fail_count = 0, n_tests = 0, cyc = 0, k, n;
  always #4 clk = ~clk;
  ibm_top DUT (.sys_clk_in(clk), .rst_in(rst), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .prd_done_in(pdone), .xfer_done_in(xdone), .drive_irq_in(irq),
    .xfer_err_in(err), .reg_rdata_out(rdata), .run_out(run),
    .mem_write_out(mw), .abort_out(ab), .prd_addr_out(paddr));
  ibm_drive_model u_drv (.sys_clk_in(clk), .rst_in(rst), .run_in(run),
    .go_in(go), .fail_in(fail), .prd_done_out(pdone),
    .xfer_done_out(xdone), .irq_out(irq), .err_out(err));
  task automatic check(input string s, input logic [31:0] e,
                       input logic [31:0] v);
    n_tests++;
    if (v !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    {addr, wdata, wr} = {a, d, 1'b1};
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk);
    {addr, rd} = {a, 1'b1};
    @(negedge clk);
    rd = 1'b0;
    check($sformatf("reg %h", a), e, rdata);
  endtask
  task automatic run_job(input int ch);
    @(negedge clk);
    go[ch] = 1'b1;
    @(negedge clk);
    go[ch] = 1'b0;
    for (k = 0; k < 60 && run[ch] !== 1'b0; k++) @(negedge clk);
    check("run end", 32'h0000_0000, {31'h0, run[ch]});
  endtask
  task automatic summarize;
    if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (n = 0; n < 16; n += 2) rd_chk(n[7:0], 32'h0000_0000);
    wr_reg(8'h00, 32'h0000_00fe);
    rd_chk(8'h00, 32'h0000_0008);
    check("dir", 32'h0000_0001, {31'h0, mw[0]});
    wr_reg(8'h02, 32'h0000_00ff);
    rd_chk(8'h02, 32'h0000_0060);
    wr_reg(8'h04, 32'h0000_1233);
    rd_chk(8'h04, 32'h0000_1230);
    wr_reg(8'h00, 32'h0000_0009);
    rd_chk(8'h02, 32'h0000_0061);
    wr_reg(8'h04, 32'h0000_5550);
    rd_chk(8'h04, 32'h0000_1230);
    run_job(0);
    rd_chk(8'h04, 32'h0000_1240);
    check("ptr", 32'h0000_1240, paddr[31:0]);
    rd_chk(8'h02, 32'h0000_0064);
    wr_reg(8'h02, 32'h0000_0064);
    rd_chk(8'h02, 32'h0000_0060);
    wr_reg(8'h00, 32'h0000_0008);
    wr_reg(8'h0c, 32'h0000_0100);
    wr_reg(8'h08, 32'h0000_0001);
    rd_chk(8'h0a, 32'h0000_0001);
    check("dir1", 32'h0000_0000, {31'h0, mw[1]});
    run_job(1);
    rd_chk(8'h0c, 32'h0000_0108);
    check("ptr1", 32'h0000_0108, paddr[63:32]);
    rd_chk(8'h0a, 32'h0000_0002);
    wr_reg(8'h0a, 32'h0000_0002);
    rd_chk(8'h0a, 32'h0000_0000);
    wr_reg(8'h00, 32'h0000_0001);
    @(negedge clk);
    go[0] = 1'b1;
    wr_reg(8'h00, 32'h0000_0000);
    go[0] = 1'b0;
    n = 0;
    repeat (6) begin
      @(negedge clk);
      n += (ab[0] === 1'b1);
    end
    check("abort", 32'h0000_0001, n);
    rd_chk(8'h02, 32'h0000_0060);
    summarize();
  end
endmodule
